// [hw/gpo_delay_filter.sv]
`timescale 1ns/10ps
`include "supply_gpo_defs.svh"
module gpo_delay_filter
    import supply_gpo_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ms_tick,
    input wire logic i_cond,
    input wire logic [3:0] i_on_code,
    input wire logic [3:0] i_off_code,
    output logic o_level
);

function automatic logic [11:0] delay_ms(input logic [3:0] code);
    logic [11:0] v;
    v = 12'h000;
    unique case (code)
        4'h0: v = 12'd0;
        4'h1: v = 12'd5;
        4'h2: v = 12'd10;
        4'h3: v = 12'd20;
        4'h4: v = 12'd40;
        4'h5: v = 12'd60;
        4'h6: v = 12'd80;
        4'h7: v = 12'd100;
        4'h8: v = 12'd200;
        4'h9: v = 12'd400;
        4'hA: v = 12'd600;
        4'hB: v = 12'd800;
        4'hC: v = 12'd1000;
        4'hD: v = 12'd1500;
        4'hE: v = 12'd2000;
        4'hF: v = 12'd4000;
    endcase
    return v;
endfunction : delay_ms

logic [11:0] ms_q;
logic prev_q;
logic [11:0] target;

assign target = i_cond ? delay_ms(i_on_code) : delay_ms(i_off_code);

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        prev_q <= 1'b0;
    else
        prev_q <= i_cond;
end

// any input change restarts the wait
always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        ms_q <= 12'h000;
    else if (i_cond != prev_q || i_cond == o_level)
        ms_q <= 12'h000;
    else if (i_ms_tick && ms_q < target)
        ms_q <= ms_q + 12'h001;
end

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        o_level <= 1'b0;
    else if (i_cond == prev_q && i_cond != o_level && ms_q >= target)
        o_level <= i_cond;
end

endmodule : gpo_delay_filter

// [hw/supply_gpo_defs.svh]
`ifndef SUPPLY_GPO_DEFS_SVH
`define SUPPLY_GPO_DEFS_SVH

`define REG_TIMEOUT_LIMIT 8'hE6
`define REG_PIN_CONFIG 8'hE7
`define NUM_CHANNELS 16
`define NUM_SEQ_CHANNELS 12
`define NUM_SENSORS 5
`define CH_SEL_SEQ_VOLT 6'h10
`define CH_SEL_VOLT 6'h20
`define CH_SEL_CURR 6'h22
`define CFG_SELECT_LSB 0
`define CFG_POLARITY_BIT 6
`define CFG_DRIVE_BIT 7
`define CFG_ON_DELAY_LSB 8
`define CFG_OFF_DELAY_LSB 12
`define CFG_MASK_LSB 16
`define CFG_WRITE_MASK 32'hFFFF_FFC7
`define CFG_RESET 32'h0000_0000
`define LIMIT_RESET 16'h0000
`define SPECIAL_FAULT_PAGE 4'h7
`define CLK_HZ 40000000
`define MS_UNIT 1
`define CYCLES_PER_MS (`CLK_HZ / 1000 * `MS_UNIT)

`endif

// [hw/supply_gpo_fault_logic.sv]
// Operation
// - overvoltage checked on 10h/20h channels
// - undervoltage armed only above power-good-on
// - overcurrent checked only on 22h
// - power-up timeout only during sequencing, 10h
// - overtemperature checked while sensor enabled
// - timeout counts milliseconds from group start
// - two-byte limit, zero disables check
// - timeout sets summary and turn-on flags
// - timeout triggers response; alert if enabled
// - code 101 special fault, page 7
// - bits 31:16: bit N+16 selects channel N
// - function 011 ANDs selected good inputs
// - function 100 ORs selected channel alarms
// - per-channel alarm chosen by fault settings
// - four-bit assertion delay table
// - four-bit deassertion delay table
// - bit 6 sets polarity
// - bit 7 selects push-pull or open-drain
// - bits 5:3 read as zero
// - delay restarts on any input change
`timescale 1ns/10ps
`include "supply_gpo_defs.svh"
module supply_gpo_fault_logic
    import supply_gpo_pkg::*;
#(
    parameter int CYCLES_PER_MS = `CYCLES_PER_MS
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    input wire logic [3:0] i_page,
    input wire logic [15:0] i_ch_sel_flat_lo,
    input wire logic [79:0] i_ch_sel_flat,
    input wire logic [15:0] i_ch_ov,
    input wire logic [15:0] i_ch_uv,
    input wire logic [15:0] i_ch_oc,
    input wire logic [15:0] i_ch_above_pg_on,
    input wire logic [15:0] i_ch_supply_off,
    input wire logic [15:0] i_supply_good,
    input wire logic [15:0] i_general_input,
    input wire logic [31:0] i_ch_alarm_config,
    input wire logic [15:0] i_ch_warn,
    input wire logic [4:0] i_sensor_enable,
    input wire logic [4:0] i_sensor_ot,
    input wire logic i_sequencing_group_a,
    input wire logic i_sequencing_group_b,
    input wire logic i_group_choice_bit,
    input wire logic i_power_on_seq,
    input wire logic i_start_event,
    input wire logic i_alert_enable,
    input wire logic i_status_clear,
    input wire logic i_margin_pwm,
    input wire logic i_special_fault_output,
    output logic [15:0] o_ov_fault,
    output logic [15:0] o_uv_fault,
    output logic [15:0] o_oc_fault,
    output logic [4:0] o_ot_fault,
    output logic o_vout_summary,
    output logic o_turn_on_timeout_flag,
    output logic o_fault_response,
    output logic o_alert_n,
    output logic o_pin_out,
    output logic o_pin_oe
);

// ch_sel_all joins i_ch_sel_flat and i_ch_sel_flat_lo: one 6-bit select per channel in 96 bits
logic [95:0] ch_sel_all;
assign ch_sel_all = {i_ch_sel_flat, i_ch_sel_flat_lo};

function automatic logic [5:0] ch_select(input logic [95:0] all,
                                         input int ch);
    return all[ch*6 +: 6];
endfunction : ch_select

function automatic logic is_volt(input logic [5:0] s);
    return (s == `CH_SEL_SEQ_VOLT) || (s == `CH_SEL_VOLT);
endfunction : is_volt

pin_config_s cfg_q;
logic [15:0] limit_q;
timeout_status_s stat_q;
logic [15:0] uv_armed_q;
logic [15:0] alarm_sel;
logic [15:0] fault_ov_d;
logic [15:0] fault_uv_d;
logic [15:0] fault_oc_d;
logic [15:0] seq_ch;
logic [4:0] fault_ot_d;
genvar g;

// registers: writes steer pin and timeout logic, reads show stored config or limit
always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        cfg_q <= `CFG_RESET;
    else if (i_reg_wr && i_reg_addr == `REG_PIN_CONFIG)
        cfg_q <= i_reg_wdata & `CFG_WRITE_MASK;
end

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        limit_q <= `LIMIT_RESET;
    else if (i_reg_wr && i_reg_addr == `REG_TIMEOUT_LIMIT)
        limit_q <= i_reg_wdata[15:0];
end

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        o_reg_rdata <= 32'h0000_0000;
    else if (i_reg_addr == `REG_PIN_CONFIG)
        o_reg_rdata <= cfg_q;
    else if (i_reg_addr == `REG_TIMEOUT_LIMIT)
        o_reg_rdata <= {16'h0000, limit_q};
    else
        o_reg_rdata <= 32'h0000_0000;
end

// per-channel fault qualification
generate
    for (g = 0; g < `NUM_CHANNELS; g++)
    begin : g_ch
        assign fault_ov_d[g] = is_volt(ch_select(ch_sel_all, g)) &
                               i_ch_ov[g];
        assign fault_uv_d[g] = is_volt(ch_select(ch_sel_all, g)) &
                               uv_armed_q[g] & i_ch_uv[g];
        assign fault_oc_d[g] = (ch_select(ch_sel_all, g) ==
                                `CH_SEL_CURR) & i_ch_oc[g];
        assign seq_ch[g] = (ch_select(ch_sel_all, g) ==
                            `CH_SEL_SEQ_VOLT);
        assign alarm_sel[g] = i_ch_alarm_config[g*2 +: 2] == 2'h0 ?
                              1'b0 :
                              i_ch_alarm_config[g*2 +: 2] == 2'h1 ?
                              i_ch_warn[g] :
                              i_ch_alarm_config[g*2 +: 2] == 2'h2 ?
                              (fault_ov_d[g] | fault_uv_d[g] |
                               fault_oc_d[g]) :
                              (i_ch_warn[g] | fault_ov_d[g] |
                               fault_uv_d[g] | fault_oc_d[g]);
    end
    for (g = 0; g < `NUM_SENSORS; g++)
    begin : g_ot
        assign fault_ot_d[g] = i_sensor_enable[g] & i_sensor_ot[g];
    end
endgenerate

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        uv_armed_q <= 16'h0000;
    else
        uv_armed_q <= (uv_armed_q | i_ch_above_pg_on) & ~i_ch_supply_off;
end

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        o_ov_fault <= 16'h0000;
        o_uv_fault <= 16'h0000;
        o_oc_fault <= 16'h0000;
        o_ot_fault <= 5'h00;
    end
    else
    begin
        o_ov_fault <= fault_ov_d;
        o_uv_fault <= fault_uv_d;
        o_oc_fault <= fault_oc_d;
        o_ot_fault <= fault_ot_d;
    end
end

// millisecond enable pulse
logic [15:0] div_q;
logic ms_tick_q;
always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        div_q <= 16'h0000;
        ms_tick_q <= 1'b0;
    end
    else if (div_q == 16'(CYCLES_PER_MS - 1))
    begin
        div_q <= 16'h0000;
        ms_tick_q <= 1'b1;
    end
    else
    begin
        div_q <= div_q + 16'h0001;
        ms_tick_q <= 1'b0;
    end
end

// start timeout
typedef enum logic [1:0] {T_IDLE, T_RUN, T_DONE} tmo_state_e;
tmo_state_e tmo_q;
logic [15:0] tmo_ms_q;
logic group_go;
logic page_seq;

assign group_go = i_group_choice_bit ? i_sequencing_group_b :
                  i_sequencing_group_a;
// only sequencing+voltage channel of this page
assign page_seq = seq_ch[i_page];

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        tmo_q <= T_IDLE;
    else
        unique case (tmo_q)
            T_IDLE:
                if (group_go && i_power_on_seq && page_seq &&
                    limit_q != 16'h0000)
                    tmo_q <= T_RUN;
            T_RUN:
                if (!i_power_on_seq || limit_q == 16'h0000)
                    tmo_q <= T_IDLE;
                // event parks in done: a held group must not re-arm
                else if (i_start_event || (ms_tick_q &&
                         tmo_ms_q + 16'h0001 >= limit_q))
                    tmo_q <= T_DONE;
            T_DONE:
                if (!i_power_on_seq)
                    tmo_q <= T_IDLE;
        endcase
end

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        tmo_ms_q <= 16'h0000;
    else if (tmo_q != T_RUN)
        tmo_ms_q <= 16'h0000;
    else if (ms_tick_q)
        tmo_ms_q <= tmo_ms_q + 16'h0001;
end

logic expire;
assign expire = (tmo_q == T_RUN) && !i_start_event && i_power_on_seq &&
                limit_q != 16'h0000 && ms_tick_q &&
                tmo_ms_q + 16'h0001 >= limit_q;

// sticky flags, set wins over clear
always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        stat_q <= '0;
    else if (expire)
    begin
        stat_q.timeout_limit_exceeded <= 1'b1;
        stat_q.vout_summary <= 1'b1;
        stat_q.turn_on_timeout_flag <= 1'b1;
        stat_q.alert <= stat_q.alert | i_alert_enable;
    end
    else if (i_status_clear)
        stat_q <= '0;
end

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        o_vout_summary <= 1'b0;
        o_turn_on_timeout_flag <= 1'b0;
        o_alert_n <= 1'b1;
        o_fault_response <= 1'b0;
    end
    else
    begin
        o_vout_summary <= stat_q.vout_summary;
        o_turn_on_timeout_flag <= stat_q.turn_on_timeout_flag;
        o_alert_n <= ~stat_q.alert;
        o_fault_response <= expire;
    end
end

// pin function
logic good_and;
logic alarm_or;
logic combo;
logic filtered;
logic active;
logic level;

// mask bit N+16 selects channel N
assign good_and = &((i_supply_good | i_general_input) |
                    ~cfg_q.good_input_channel_mask);
assign alarm_or = |(alarm_sel & cfg_q.good_input_channel_mask);
assign combo = (cfg_q.select == FN_GOOD_AND) ? good_and : alarm_or;

gpo_delay_filter u_delay (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ms_tick(ms_tick_q),
    .i_cond(combo),
    .i_on_code(cfg_q.on_delay),
    .i_off_code(cfg_q.off_delay),
    .o_level(filtered)
);

always_comb
begin
    active = 1'b0;
    unique case (cfg_q.select)
        FN_PWM: active = i_margin_pwm;
        FN_FORCE_ON: active = 1'b1;
        FN_FORCE_OFF: active = 1'b0;
        FN_GOOD_AND: active = filtered;
        FN_ALARM_OR: active = filtered;
        // special output only on page 7
        FN_SPECIAL: active = (i_page == `SPECIAL_FAULT_PAGE) &
                             i_special_fault_output;
        // reserved codes hold the pin deasserted
        FN_RSVD6: active = 1'b0;
        FN_RSVD7: active = 1'b0;
    endcase
end

assign level = cfg_q.polarity_bit ? active : ~active;

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        o_pin_out <= 1'b0;
        o_pin_oe <= 1'b0;
    end
    else if (cfg_q.drive_type_bit)
    begin
        o_pin_out <= 1'b0;
        o_pin_oe <= ~level;
    end
    else
    begin
        o_pin_out <= level;
        o_pin_oe <= 1'b1;
    end
end

endmodule : supply_gpo_fault_logic

// [hw/supply_gpo_pkg.sv]
package supply_gpo_pkg;

typedef enum logic [2:0] {
    FN_PWM = 3'h0,
    FN_FORCE_ON = 3'h1,
    FN_FORCE_OFF = 3'h2,
    FN_GOOD_AND = 3'h3,
    FN_ALARM_OR = 3'h4,
    FN_SPECIAL = 3'h5,
    FN_RSVD6 = 3'h6,
    FN_RSVD7 = 3'h7
} pin_function_e;

typedef struct packed {
    logic [15:0] good_input_channel_mask;
    logic [3:0] off_delay;
    logic [3:0] on_delay;
    logic drive_type_bit;
    logic polarity_bit;
    logic [2:0] zero_bits;
    logic [2:0] select;
} pin_config_s;

typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
} reg_write_s;

typedef struct packed {
    logic timeout_limit_exceeded;
    logic vout_summary;
    logic turn_on_timeout_flag;
    logic alert;
} timeout_status_s;

endpackage : supply_gpo_pkg

// [test/gpo_props.sv]
`timescale 1ns/10ps
module gpo_props
    import supply_gpo_pkg::*;
#(
    parameter int CYCLES_PER_MS = 4
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_ch_sel_flat_lo,
    input wire logic [15:0] i_ch_ov,
    input wire logic [15:0] i_ch_oc,
    input wire logic i_alert_enable,
    input wire logic [31:0] o_reg_rdata,
    input wire logic [15:0] o_ov_fault,
    input wire logic [15:0] o_oc_fault,
    input wire logic o_vout_summary,
    input wire logic o_turn_on_timeout_flag,
    input wire logic o_fault_response,
    input wire logic o_alert_n,
    input wire logic o_pin_out,
    input wire logic o_pin_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [5:0] sel0;
    assign sel0 = i_ch_sel_flat_lo[5:0];
    sequence expiry_s;
        o_fault_response && !o_turn_on_timeout_flag;
    endsequence
    sequence flags_s;
        o_vout_summary && o_turn_on_timeout_flag;
    endsequence
    // three equal samples, so the pin has caught up with the config
    sequence cfg_held_s;
        $past(i_reg_addr) == 8'hE7 && $stable(o_reg_rdata)
            && $past(o_reg_rdata) == $past(o_reg_rdata, 2);
    endsequence
    ov_gate_a:
    assert property (o_ov_fault[0] ==
        $past(i_ch_ov[0] && (sel0 == 6'h10 || sel0 == 6'h20)))
        else $error("overvoltage flag ignores its gate");
    oc_gate_a:
    assert property (o_oc_fault[0] == $past(i_ch_oc[0] && sel0 == 6'h22))
        else $error("overcurrent flag ignores its gate");
    zero_bits_a:
    assert property ($past(i_reg_addr) == 8'hE7 |-> o_reg_rdata[5:3] == 3'h0)
        else $error("unused config bits read nonzero");
    limit_width_a:
    assert property ($past(i_reg_addr) == 8'hE6
        |-> o_reg_rdata[31:16] == 16'h0000)
        else $error("limit wider than two bytes");
    timeout_flags_a:
    assert property (expiry_s |-> ##[1:2] flags_s)
        else $error("timeout flags missing");
    alert_gate_a:
    assert property (expiry_s ##0 $past(i_alert_enable)
        |-> ##[1:2] !o_alert_n)
        else $error("alert missing after timeout");
    alert_quiet_a:
    assert property ($fell(o_alert_n) |-> $past(i_alert_enable, 2))
        else $error("alert while disabled");
    open_drain_a:
    assert property (cfg_held_s ##0 o_reg_rdata[7] |-> !o_pin_out)
        else $error("open drain drives high");
    force_level_a:
    assert property (cfg_held_s ##0 (o_reg_rdata[2:0] inside {3'h1, 3'h2}
        && !o_reg_rdata[7])
        |-> o_pin_oe && o_pin_out == (o_reg_rdata[6] ^ o_reg_rdata[1]))
        else $error("forced pin level wrong");
endmodule : gpo_props

bind supply_gpo_fault_logic gpo_props #(.CYCLES_PER_MS(CYCLES_PER_MS))
    props (.*);

// [test/rail_model.sv]
`timescale 1ns/10ps
module rail_model
(
    input wire logic i_pin_out,
    input wire logic i_pin_oe,
    input wire logic [15:0] i_good_cmd,
    output logic o_wire,
    output logic [15:0] o_supply_good
);
    assign o_wire = i_pin_oe ? i_pin_out : 1'b1;
    assign o_supply_good = i_good_cmd;
endmodule : rail_model

// [test/supply_gpo_fault_logic_test.sv]
`timescale 1ns/10ps
module supply_gpo_fault_logic_test
    import supply_gpo_pkg::*;
;
    localparam int CPM = 4;
    logic i_clk, i_rst_n, i_reg_wr, i_group_choice_bit, i_power_on_seq;
    logic i_sequencing_group_a, i_sequencing_group_b, i_start_event;
    logic i_alert_enable, i_status_clear, i_margin_pwm, pin_wire;
    logic i_special_fault_output, o_vout_summary, o_turn_on_timeout_flag;
    logic o_fault_response, o_alert_n, o_pin_out, o_pin_oe, pol, od, act;
    logic [2:0] fn;
    logic [3:0] i_page;
    logic [7:0] i_reg_addr;
    logic [31:0] i_reg_wdata, o_reg_rdata, i_ch_alarm_config, r;
    logic [15:0] i_ch_sel_flat_lo, i_ch_ov, i_ch_uv, i_ch_oc, good_cmd;
    logic [15:0] i_ch_above_pg_on, i_ch_supply_off, i_supply_good;
    logic [15:0] i_general_input, i_ch_warn, o_ov_fault, o_uv_fault;
    logic [15:0] o_oc_fault;
    logic [79:0] i_ch_sel_flat;
    logic [4:0] i_sensor_enable, i_sensor_ot, o_ot_fault;
    logic [5:0] codes[5] = '{6'h10, 6'h20, 6'h22, 6'h21, 6'h00};
    int fails, n_compared, n;
    int dly[16] = '{0, 5, 10, 20, 40, 60, 80, 100, 200, 400, 600, 800,
        1000, 1500, 2000, 4000};

    supply_gpo_fault_logic #(.CYCLES_PER_MS(CPM)) dut (.*);
    rail_model partner (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
        .i_good_cmd(good_cmd), .o_wire(pin_wire),
        .o_supply_good(i_supply_good));

    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int c);
        repeat (c) @(negedge i_clk);
    endtask : cyc

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
        cyc(1);
        i_reg_wr = 1'b0;
    endtask : wreg

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        i_reg_addr = a;
        cyc(2);
        check(o_reg_rdata, exp);
    endtask : rd

    task automatic pin_chk(input logic a, input logic p, input logic o);
        cyc(6);
        check(pin_wire, !(a ^ p));
        check(o_pin_oe, o ? a ^ p : 1'b1);
    endtask : pin_chk

    task automatic tmo(input logic [5:0] s, input logic ch, input logic ev,
        input logic en, input logic [15:0] lim, input logic exp);
        i_ch_sel_flat_lo[5:0] = s;
        {i_group_choice_bit, i_alert_enable} = {ch, en};
        i_sequencing_group_a = 1'b1;
        wreg(8'hE6, {16'h0000, lim});
        i_power_on_seq = 1'b1;
        cyc(2 * CPM);
        check(o_turn_on_timeout_flag, 1'b0);
        i_start_event = ev;
        cyc(3 * CPM);
        check(o_turn_on_timeout_flag, exp);
        check(o_vout_summary, exp);
        check(o_alert_n, !(exp && en));
        {i_power_on_seq, i_start_event, i_status_clear} = 3'h1;
        cyc(1);
        i_status_clear = 1'b0;
        cyc(2);
        check(o_turn_on_timeout_flag, 1'b0);
    endtask : tmo

    initial
    begin
        #2000000;
        fails++;
        results();
    end

    initial
    begin
        {i_reg_wr, i_group_choice_bit, i_power_on_seq, i_sequencing_group_a,
            i_sequencing_group_b, i_start_event, i_alert_enable, pol, od,
            i_status_clear, i_margin_pwm, i_special_fault_output} = '0;
        {i_rst_n, i_reg_addr, i_reg_wdata, i_ch_alarm_config, i_page} = '0;
        {i_ch_sel_flat_lo, i_ch_ov, i_ch_uv, i_ch_oc, good_cmd} = '0;
        {i_ch_above_pg_on, i_ch_supply_off, i_general_input} = '0;
        {i_ch_warn, i_ch_sel_flat, i_sensor_enable, i_sensor_ot} = '0;
        void'($urandom(32'h76dcb152));
        cyc(3);
        i_rst_n = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            r = $urandom;
            wreg(8'hE7, r);
            rd(8'hE7, r & 32'hFFFF_FFC7);
            wreg(8'hE6, r);
            rd(8'hE6, r & 32'h0000_FFFF);
        end
        rd(8'h55, 32'h0000_0000);
        $display("registers done");
        {i_ch_ov, i_ch_oc, i_ch_uv, i_ch_supply_off} = {4{16'h0001}};
        foreach (codes[i])
        begin
            i_ch_sel_flat_lo[5:0] = codes[i];
            cyc(2);
            check(o_ov_fault[0], codes[i] inside {6'h10, 6'h20});
            check(o_oc_fault[0], codes[i] == 6'h22);
            check(o_uv_fault[0], 1'b0);
        end
        i_ch_sel_flat_lo[5:0] = 6'h20;
        {i_ch_above_pg_on, i_ch_supply_off} = {16'h0001, 16'h0000};
        cyc(2);
        check(o_uv_fault[0], 1'b1);
        {i_ch_above_pg_on, i_ch_supply_off} = {16'h0000, 16'h0001};
        cyc(2);
        check(o_uv_fault[0], 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            i_sensor_enable = i ? 5'h1F : 5'h00;
            i_sensor_ot = 5'($urandom);
            cyc(2);
            check(o_ot_fault, i_sensor_ot & i_sensor_enable);
        end
        $display("fault gating done");
        {i_page, i_special_fault_output} = {4'h7, 1'b1};
        for (int k = 0; k < 32; k++)
        begin
            {fn, pol, od} = 5'(k);
            if (fn == 3'h3 || fn == 3'h4)
                continue;
            i_margin_pwm = 1'b0;
            wreg(8'hE7, {24'h0, od, pol, 3'h0, fn});
            i_margin_pwm = 1'($urandom);
            act = fn == 3'h0 ? i_margin_pwm : fn == 3'h1 || fn == 3'h5;
            pin_chk(act, pol, od);
        end
        i_page = 4'h3;
        wreg(8'hE7, 32'h0000_0045);
        pin_chk(1'b0, 1'b1, 1'b0);
        $display("pin functions done");
        for (int c = 0; c < 16; c++)
        begin
            wreg(8'hE7, {16'h0003, 4'h0, 4'(c), 8'h43});
            pin_chk(1'b0, 1'b1, 1'b0);
            {good_cmd, i_general_input} = {16'h0005, 16'h0002};
            n = dly[c] * CPM;
            if (n > 0)
            begin
                cyc(n - CPM - 7);
                pin_chk(1'b0, 1'b1, 1'b0);
                cyc(CPM + 1);
            end
            pin_chk(1'b1, 1'b1, 1'b0);
            {good_cmd, i_general_input} = '0;
            pin_chk(1'b0, 1'b1, 1'b0);
        end
        wreg(8'hE7, {16'h0003, 4'h2, 4'h1, 8'h43});
        {good_cmd, i_general_input} = {16'h0001, 16'h0002};
        cyc(3 * CPM);
        i_general_input = 16'h0000;
        cyc(1);
        i_general_input = 16'h0002;
        cyc(4 * CPM - 7);
        pin_chk(1'b0, 1'b1, 1'b0);
        cyc(CPM + 2);
        pin_chk(1'b1, 1'b1, 1'b0);
        i_general_input = 16'h0000;
        cyc(9 * CPM - 7);
        pin_chk(1'b1, 1'b1, 1'b0);
        cyc(CPM + 1);
        pin_chk(1'b0, 1'b1, 1'b0);
        i_ch_alarm_config = 32'h0000_0010;
        wreg(8'hE7, 32'h0004_0044);
        i_ch_warn = 16'h0008;
        pin_chk(1'b0, 1'b1, 1'b0);
        i_ch_warn = 16'h0004;
        pin_chk(1'b1, 1'b1, 1'b0);
        i_ch_alarm_config = 32'h0000_0000;
        pin_chk(1'b0, 1'b1, 1'b0);
        i_ch_alarm_config = 32'h0000_0002;
        wreg(8'hE7, 32'h0001_0044);
        pin_chk(1'b1, 1'b1, 1'b0);
        i_ch_ov = 16'h0000;
        pin_chk(1'b0, 1'b1, 1'b0);
        {i_ch_alarm_config, i_ch_warn} = {32'h0000_0003, 16'h0001};
        pin_chk(1'b1, 1'b1, 1'b0);
        $display("delays done");
        i_page = 4'h0;
        tmo(6'h10, 1'b0, 1'b0, 1'b0, 16'h0003, 1'b1);
        tmo(6'h10, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b0);
        tmo(6'h20, 1'b0, 1'b0, 1'b0, 16'h0003, 1'b0);
        tmo(6'h10, 1'b1, 1'b0, 1'b0, 16'h0003, 1'b0);
        tmo(6'h10, 1'b0, 1'b1, 1'b0, 16'h0003, 1'b0);
        tmo(6'h10, 1'b0, 1'b0, 1'b1, 16'h0004, 1'b1);
        i_sequencing_group_b = 1'b1;
        tmo(6'h10, 1'b1, 1'b0, 1'b1, 16'h0003, 1'b1);
        $display("timeout done");
        results();
    end
endmodule : supply_gpo_fault_logic_test
